// ===== hdl/fetx_cg_decode.sv
// Code-group to nibble decoder with invalid and halt detection
`timescale 1ns/1ps
`default_nettype none
module fetx_cg_decode (
    // Code-group in
    input  wire logic [4:0]  code,
    input  wire logic        in_data,
    // Decoded result
    output fetx_pkg::fetx_rxnib_s res
);
    always_comb begin
        res = '{nib: 4'h0, err: 1'b1, halt: 1'b0};
        for (int i = 0; i < 16; i++) begin
            if (code == fetx_pkg::ENC_TABLE[i*5 +: 5]) begin
                res.nib = 4'(i);
                res.err = 1'b0;
            end
        end
        if (code == fetx_pkg::CG_J || code == fetx_pkg::CG_K) begin
            res.nib = fetx_pkg::NIB_JK;
            res.err = in_data;
        end
        if (code == fetx_pkg::CG_IDLE || code == fetx_pkg::CG_T
                || code == fetx_pkg::CG_R) begin
            res.nib = fetx_pkg::NIB_CTL;
            res.err = in_data;
        end
        if (code == fetx_pkg::CG_HALT) begin
            res.halt = 1'b1;
        end
    end

endmodule // fetx_cg_decode
`default_nettype wire

// ===== hdl/fetx_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module fetx_fifo #(
    parameter int W     = 5,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    // Fill side
    input  wire logic         in_valid,
    output var  logic         in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two, at least 2");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic [AW:0]   next_count;
    logic          push;
    logic          pop;

    assign out_valid  = count != '0;
    assign out_data   = mem[rd_ptr];
    assign push       = ce & in_valid & in_ready;
    assign pop        = ce & out_ready & out_valid;
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            count    <= '0;
            in_ready <= 1'b1;
        end else if (ce) begin
            wr_ptr   <= wr_ptr + AW'(push);
            rd_ptr   <= rd_ptr + AW'(pop);
            count    <= next_count;
            in_ready <= next_count != (AW+1)'(DEPTH);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule // fetx_fifo
`default_nettype wire

// ===== hdl/fetx_pkg.sv
// Shared constants, code tables and carrier types for the transmit coding path
package fetx_pkg;

    // ------------------------------------------------------------
    // Code-groups
    // ------------------------------------------------------------
    localparam logic [4:0] CG_IDLE = 5'h1f;
    localparam logic [4:0] CG_J    = 5'h18;
    localparam logic [4:0] CG_K    = 5'h11;
    localparam logic [4:0] CG_T    = 5'h0d;
    localparam logic [4:0] CG_R    = 5'h07;
    localparam logic [4:0] CG_HALT = 5'h04;
    localparam logic [3:0] NIB_JK  = 4'h5;
    localparam logic [3:0] NIB_CTL = 4'h0;
    // Data code-groups, entry n at bits [5n+4:5n]
    localparam logic [79:0] ENC_TABLE = {
        5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12,
        5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};

    // ------------------------------------------------------------
    // Timing and sizes
    // ------------------------------------------------------------
    localparam logic [7:0] CLK_MHZ    = 8'hc8;
    localparam logic [7:0] SYM_MHZ    = 8'h7d;
    localparam logic [2:0] CG_LAST    = 3'h4;
    localparam int         FIFO_DEPTH = 4;
    localparam logic [1:0] SEED_WAIT  = 2'h3;
    localparam int         TAP_HI     = 10;
    localparam int         TAP_LO     = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SSD_K = 2'b01,
        ST_DATA  = 2'b10,
        ST_ESD_R = 2'b11
    } fetx_state_e;

    typedef struct packed {
        logic       en;
        logic [3:0] nib;
    } fetx_word_s;

    typedef struct packed {
        logic       valid;
        logic       in_data;
        logic [4:0] code;
    } fetx_rxcg_s;

    typedef struct packed {
        logic [3:0] nib;
        logic       err;
        logic       halt;
    } fetx_rxnib_s;

    function automatic logic [4:0] fetx_enc(input logic [3:0] n);
        return ENC_TABLE[n*5 +: 5];
    endfunction

endpackage

// ===== hdl/fetx_tx_pcs.sv
// Fast Ethernet transmit coding path: 4B/5B, scrambler, NRZI, MLT-3
`timescale 1ns/1ps
`default_nettype none
module fetx_tx_pcs #(
    parameter int FIFO_W     = 5,
    parameter int FIFO_DEPTH = fetx_pkg::FIFO_DEPTH
) (
    // Clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 ce,
    // MAC transmit words
    input  wire fetx_pkg::fetx_word_s tx_word,
    input  wire logic                 tx_valid,
    output logic                      tx_ready,
    // Straps and mode
    input  wire logic [4:0]           strap_address_pins,
    input  wire logic                 scr_bypass,
    // Line drive streams
    output var  logic                 mlt_pos,
    output var  logic                 mlt_neg,
    output var  logic                 bit_tick,
    // Code-group decode
    input  wire fetx_pkg::fetx_rxcg_s rx_cg,
    output var  fetx_pkg::fetx_rxnib_s rx_out,
    output var  logic                 rx_out_valid
);
    if (FIFO_W != $bits(fetx_pkg::fetx_word_s) || FIFO_DEPTH < 2) begin : g_bad
        $error("fifo width must match the word struct and depth be at least 2");
    end

    // ------------------------------------------------------------
    // Input buffer
    // ------------------------------------------------------------
    fetx_pkg::fetx_word_s head;
    logic                 head_valid;
    logic                 pop;

    fetx_fifo #(
        .W     (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_word),
        .out_valid (head_valid),
        .out_ready (pop),
        .out_data  (head)
    );

    // ------------------------------------------------------------
    // Bit rate generator
    // ------------------------------------------------------------
    logic [7:0] acc;
    logic [8:0] acc_sum;
    logic       next_tick;
    logic [7:0] next_acc;

    assign acc_sum   = {1'b0, acc} + {1'b0, fetx_pkg::SYM_MHZ};
    assign next_tick = acc_sum >= {1'b0, fetx_pkg::CLK_MHZ};
    assign next_acc  = next_tick ? 8'(acc_sum - {1'b0, fetx_pkg::CLK_MHZ})
                                 : acc_sum[7:0];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc      <= 8'h00;
            bit_tick <= 1'b0;
        end else if (ce) begin
            acc      <= next_acc;
            bit_tick <= next_tick;
        end
    end

    // ------------------------------------------------------------
    // Strap capture and seed
    // ------------------------------------------------------------
    logic [4:0]  addr_s1;
    logic [4:0]  addr_s2;
    logic [1:0]  seed_wait;
    logic        seeded;
    logic [10:0] seed;

    assign seed = {1'b1, addr_s2, ~addr_s2};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_s1   <= 5'h00;
            addr_s2   <= 5'h00;
            seed_wait <= 2'h0;
        end else if (ce) begin
            addr_s1   <= strap_address_pins;
            addr_s2   <= addr_s1;
            seed_wait <= (seed_wait == fetx_pkg::SEED_WAIT) ? seed_wait
                                                            : seed_wait + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------
    fetx_pkg::fetx_state_e st;
    fetx_pkg::fetx_state_e next_st;
    logic [2:0] bit_cnt;
    logic       run;
    logic       grp;
    logic       pop_req;
    logic [4:0] code;
    logic       frame_word;

    assign run        = bit_tick & seeded & ce;
    assign grp        = run & (bit_cnt == 3'h0);
    assign frame_word = head_valid & head.en;
    assign pop        = grp & pop_req;

    always_comb begin
        next_st = st;
        code    = fetx_pkg::CG_IDLE;
        pop_req = 1'b0;
        unique case (st)
            fetx_pkg::ST_IDLE: begin
                if (frame_word) begin
                    code    = fetx_pkg::CG_J;
                    next_st = fetx_pkg::ST_SSD_K;
                end
                pop_req = head_valid;
            end
            fetx_pkg::ST_SSD_K: begin
                code    = fetx_pkg::CG_K;
                pop_req = frame_word;
                next_st = fetx_pkg::ST_DATA;
            end
            fetx_pkg::ST_DATA: begin
                if (frame_word) begin
                    code    = fetx_pkg::fetx_enc(head.nib);
                    pop_req = 1'b1;
                end else begin
                    code    = fetx_pkg::CG_T;
                    next_st = fetx_pkg::ST_ESD_R;
                end
            end
            fetx_pkg::ST_ESD_R: begin
                code    = fetx_pkg::CG_R;
                next_st = fetx_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st      <= fetx_pkg::ST_IDLE;
            bit_cnt <= 3'h0;
        end else if (run) begin
            if (bit_cnt == 3'h0) begin
                st <= next_st;
            end
            bit_cnt <= (bit_cnt == fetx_pkg::CG_LAST) ? 3'h0 : bit_cnt + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Serialiser, scrambler, NRZI, MLT-3
    // ------------------------------------------------------------
    logic [4:0]  sh;
    logic        nrz_bit;
    logic        key_bit;
    logic        scr_bit;
    logic [10:0] lfsr;
    logic        nrzi;
    logic        next_nrzi;
    logic        phase;
    logic        next_phase;

    assign nrz_bit    = grp ? code[4] : sh[4];
    assign key_bit    = lfsr[fetx_pkg::TAP_HI] ^ lfsr[fetx_pkg::TAP_LO];
    assign scr_bit    = nrz_bit ^ (key_bit & ~scr_bypass);
    assign next_nrzi  = nrzi ^ scr_bit;
    assign next_phase = phase ^ (nrzi & ~next_nrzi);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            seeded <= 1'b0;
            lfsr   <= 11'h7ff;
        end else if (ce && !seeded && seed_wait == fetx_pkg::SEED_WAIT) begin
            seeded <= 1'b1;
            lfsr   <= seed;
        end else if (run) begin
            lfsr <= {lfsr[9:0], key_bit};
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sh      <= 5'h1f;
            nrzi    <= 1'b0;
            phase   <= 1'b0;
            mlt_pos <= 1'b0;
            mlt_neg <= 1'b0;
        end else if (run) begin
            sh      <= grp ? {code[3:0], 1'b0} : {sh[3:0], 1'b0};
            nrzi    <= next_nrzi;
            phase   <= next_phase;
            // only one stream high at a time
            mlt_pos <= next_nrzi & ~next_phase;
            mlt_neg <= next_nrzi & next_phase;
        end
    end

    // ------------------------------------------------------------
    // Code-group decode
    // ------------------------------------------------------------
    fetx_pkg::fetx_rxnib_s dec;

    fetx_cg_decode u_dec (
        .code    (rx_cg.code),
        .in_data (rx_cg.in_data),
        .res     (dec)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_out       <= '0;
            rx_out_valid <= 1'b0;
        end else if (ce) begin
            rx_out       <= dec;
            rx_out_valid <= rx_cg.valid;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_t_sent;
        grp && st == fetx_pkg::ST_DATA && !frame_word;
    endsequence

    sequence s_r_slot;
        st == fetx_pkg::ST_ESD_R && code == fetx_pkg::CG_R;
    endsequence

    a_jk_pair: assert property (
        grp && st == fetx_pkg::ST_IDLE && frame_word
        |-> code == fetx_pkg::CG_J ##1 st == fetx_pkg::ST_SSD_K
            && code == fetx_pkg::CG_K)
        else $error("start delimiter not J then K");

    a_data_encode: assert property (
        grp && st == fetx_pkg::ST_DATA && frame_word
        |-> code == fetx_pkg::fetx_enc(head.nib) && pop)
        else $error("data nibble not encoded from table");

    a_tr_close: assert property (
        s_t_sent |-> code == fetx_pkg::CG_T ##1 s_r_slot)
        else $error("end delimiter not T then R");

    a_idle_fill: assert property (
        grp && st == fetx_pkg::ST_IDLE && !frame_word
        |-> code == fetx_pkg::CG_IDLE)
        else $error("idle gap not filled with idle");

    a_bit_rate: assert property (
        (ce && bit_tick) [*2] |=> !bit_tick)
        else $error("bit tick rate above 5 of 8 clocks");

    a_group_len: assert property (
        grp |=> !grp [*4])
        else $error("code-group shorter than five bit ticks");

    a_mlt_levels: assert property (
        !(mlt_pos && mlt_neg))
        else $error("both line streams high");

    a_nrzi_toggle: assert property (
        run |=> nrzi == ($past(nrzi) ^ $past(scr_bit)))
        else $error("nrzi did not follow input bit");

    a_scr_bypass: assert property (
        run && scr_bypass |-> scr_bit == nrz_bit)
        else $error("bypass altered serial bit");

    a_seed_load: assert property (
        $rose(seeded) |-> lfsr == {1'b1, $past(addr_s2), ~$past(addr_s2)})
        else $error("seed not taken from straps");

    a_rx_invalid: assert property (
        rx_cg.valid && ce && (rx_cg.code == 5'h00 || rx_cg.code == 5'h0c)
        |=> rx_out.err)
        else $error("invalid code-group not flagged");

    a_rx_jk_nib: assert property (
        ce && (rx_cg.code == fetx_pkg::CG_J || rx_cg.code == fetx_pkg::CG_K)
        |=> rx_out.nib == fetx_pkg::NIB_JK)
        else $error("J or K not decoded to 0101");

endmodule // fetx_tx_pcs
`default_nettype wire

// ===== tb/fetx_mac_model.sv
// MAC transmit model: offers queued nibble words over valid/ready
`timescale 1ns/1ps
`default_nettype none
module fetx_mac_model (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            sys_rst,
    // Word handshake
    output fetx_pkg::fetx_word_s tx_word,
    output logic                 tx_valid,
    input  wire logic            tx_ready,
    // Status
    output logic                 busy
);
    fetx_pkg::fetx_word_s wq[$];
    int                   gq[$];
    int                   gap_n;

    task automatic load(input fetx_pkg::fetx_word_s w, input int gap);
        wq.push_back(w);
        gq.push_back(gap);
        busy = 1'b1;
    endtask

    initial begin
        tx_valid = 1'b0;
        tx_word  = '0;
        busy     = 1'b0;
        forever begin
            @(posedge clk);
            if (!sys_rst && wq.size() != 0) begin
                #1;
                tx_word  = wq.pop_front();
                gap_n    = gq.pop_front();
                tx_valid = 1'b1;
                do @(posedge clk); while (tx_ready !== 1'b1);
                #1;
                tx_valid = 1'b0;
                // Released word shows the last value inverted, not the last value
                tx_word  = ~tx_word;
                repeat (gap_n) @(posedge clk);
                busy = (wq.size() != 0);
            end
        end
    end
endmodule // fetx_mac_model
`default_nettype wire

// ===== tb/fetx_tx_pcs_bench.sv
// Self-checking bench for the transmit coding path
`timescale 1ns/1ps
`default_nettype none
module fetx_tx_pcs_bench;
    logic                  clk, sys_rst, ce, scr_bypass, tx_valid, tx_ready;
    logic                  mlt_pos, mlt_neg, bit_tick, rx_out_valid, mac_busy;
    logic [4:0]            strap_address_pins;
    fetx_pkg::fetx_word_s  tx_word;
    fetx_pkg::fetx_rxcg_s  rx_cg;
    fetx_pkg::fetx_rxnib_s rx_out;
    int                    num_errors = 0;
    int                    checked = 0;
    int                    cycles = 0;
    logic                  tick_d = 0, nrzi_q = 0, last_pos = 0, seen_hi = 0, saw_full = 0;
    logic                  bits[$];
    logic [4:0]            enc_t[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
        5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

    fetx_tx_pcs u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .tx_word(tx_word),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .strap_address_pins(strap_address_pins),
        .scr_bypass(scr_bypass), .mlt_pos(mlt_pos), .mlt_neg(mlt_neg), .bit_tick(bit_tick),
        .rx_cg(rx_cg), .rx_out(rx_out), .rx_out_valid(rx_out_valid));
    fetx_mac_model u_mac (.clk(clk), .sys_rst(sys_rst), .tx_word(tx_word),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .busy(mac_busy));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim;
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Line monitor: MLT-3 back to NRZ bits
    // ------------------------------------------------------------
    always @(posedge clk) begin
        tick_d <= bit_tick & ce;
        if (tx_ready === 1'b0) saw_full = 1'b1;
        if (sys_rst) begin
            nrzi_q  = 1'b0;
            seen_hi = 1'b0;
        end else begin
            chk("mlt streams exclusive", 32'h0, mlt_pos & mlt_neg);
            if (tick_d) begin
                bits.push_back((mlt_pos | mlt_neg) ^ nrzi_q);
                if ((mlt_pos | mlt_neg) && !nrzi_q) begin
                    if (seen_hi) chk("mlt alternation", !last_pos, mlt_pos);
                    last_pos = mlt_pos;
                    seen_hi  = 1'b1;
                end
                nrzi_q = mlt_pos | mlt_neg;
            end
        end
    end

    function automatic logic [9:0] grab(input int at, input int n);
        logic [9:0] v;
        v = '0;
        for (int j = 0; j < n; j++) v = {v[8:0], bits[at+j]};
        return v;
    endfunction

    task automatic do_reset;
        sys_rst = 1'b1;
        repeat (6) @(posedge clk);
        #1 sys_rst = 1'b0;
    endtask

    task automatic wait_bits(input int n);
        for (int k = 0; k < 4000 && bits.size() < n; k++) @(posedge clk);
        #1;
        chk("line bit count", 32'h1, bits.size() >= n);
    endtask

    task automatic wait_mac;
        for (int k = 0; k < 2000 && mac_busy; k++) @(posedge clk);
        #1;
        chk("mac queue drained", 32'h0, mac_busy);
    endtask

    task automatic chk_line(input string what, input logic [4:0] ex[$]);
        int p;
        p = -1;
        for (int k = 0; k < 6000 && p < 0; k++) begin
            @(posedge clk);
            for (int i = 0; i + 10 <= bits.size() && p < 0; i++)
                if (grab(i, 10) === {fetx_pkg::CG_J, fetx_pkg::CG_K}) p = i;
        end
        chk("start delimiter found", 32'h1, p >= 0);
        if (p < 0) return;
        wait_bits(p + 5 * ex.size());
        for (int i = 0; i < ex.size(); i++) chk(what, ex[i], grab(p + 5 * i, 5));
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_seed;
        logic [39:0] key[2];
        for (int a = 0; a < 2; a++) begin
            strap_address_pins = (a == 0) ? 5'h01 : 5'h1e;
            do_reset();
            bits.delete();
            wait_bits(40);
            for (int i = 0; i < 40; i++) key[a][i] = bits[i];
        end
        chk("seed streams differ", 32'h1, key[0] !== key[1]);
    endtask

    task automatic t_rate;
        int n;
        n = 0;
        for (int k = 0; k < 80; k++) begin
            @(posedge clk);
            #1;
            if (bit_tick === 1'b1) n++;
        end
        chk("bit ticks per 80 clocks", 32'h32, n);
    endtask

    // Clock enable low must freeze the tick and the line drive
    task automatic t_hold;
        logic [2:0] snap;
        @(posedge clk);
        #1 ce = 1'b0;
        snap = {bit_tick, mlt_pos, mlt_neg};
        for (int k = 0; k < 20; k++) begin
            @(posedge clk);
            #1;
            chk("frozen tick and line", snap, {bit_tick, mlt_pos, mlt_neg});
        end
        ce = 1'b1;
    endtask

    task automatic t_decode;
        logic [3:0] n;
        logic       e, nk;
        for (int d = 0; d < 2; d++) begin
            for (int c = 0; c < 32; c++) begin
                n  = 4'h0;
                e  = 1'b1;
                nk = 1'b0;
                for (int i = 0; i < 16; i++)
                    if (enc_t[i] == c[4:0]) {n, e, nk} = {i[3:0], 1'b0, 1'b1};
                if (c[4:0] == fetx_pkg::CG_IDLE || c[4:0] == fetx_pkg::CG_T
                    || c[4:0] == fetx_pkg::CG_R) {n, e, nk} = {4'h0, d[0], 1'b1};
                if (c[4:0] == fetx_pkg::CG_J || c[4:0] == fetx_pkg::CG_K)
                    {n, e, nk} = {4'h5, d[0], 1'b1};
                @(posedge clk);
                #1 rx_cg = {1'b1, d[0], c[4:0]};
                @(posedge clk);
                #1;
                chk("rx_out_valid", 32'h1, rx_out_valid);
                chk("rx error flag", e, rx_out.err);
                chk("rx halt flag", c[4:0] == 5'h04, rx_out.halt);
                if (nk) chk("rx nibble", n, rx_out.nib);
            end
        end
        rx_cg = '0;
    endtask

    task automatic t_scramble;
        int bad, ones;
        scr_bypass = 1'b0;
        bits.delete();
        wait_bits(120);
        bad  = 0;
        ones = 0;
        for (int n = 20; n < 120; n++) begin
            ones += bits[n];
            if ((bits[n] ^ bits[n-11] ^ bits[n-9]) !== 1'b1) bad++;
        end
        chk("lfsr recurrence misses", 32'h0, bad);
        chk("scrambled idle not plain", 32'h1, ones != 100);
    endtask

    task automatic t_frame;
        logic [4:0] ex[$];
        scr_bypass = 1'b1;
        repeat (40) @(posedge clk);
        #1;
        bits.delete();
        saw_full = 1'b0;
        ex = '{fetx_pkg::CG_J, fetx_pkg::CG_K};
        u_mac.load({1'b1, 4'h5}, 0);
        u_mac.load({1'b1, 4'h5}, 0);
        for (int i = 0; i < 16; i++) begin
            u_mac.load({1'b1, i[3:0]}, 0);
            ex.push_back(enc_t[i]);
        end
        u_mac.load({1'b0, 4'h0}, 0);
        ex = {ex, fetx_pkg::CG_T, fetx_pkg::CG_R, fetx_pkg::CG_IDLE, fetx_pkg::CG_IDLE};
        chk_line("frame code-group", ex);
        wait_mac();
        chk("fifo refused when full", 32'h1, saw_full);
        chk("fifo drained", 32'h1, tx_ready);
    endtask

    task automatic t_underrun;
        bits.delete();
        u_mac.load({1'b1, 4'h5}, 0);
        u_mac.load({1'b1, 4'h5}, 0);
        u_mac.load({1'b1, 4'h3}, 60);
        u_mac.load({1'b0, 4'h0}, 0);
        chk_line("underrun code-group", '{fetx_pkg::CG_J, fetx_pkg::CG_K, enc_t[3],
            fetx_pkg::CG_T, fetx_pkg::CG_R, fetx_pkg::CG_IDLE, fetx_pkg::CG_IDLE});
        wait_mac();
    endtask

    initial begin
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles == 20000) begin
                num_errors++;
                end_sim();
            end
        end
    end

    initial begin
        sys_rst            = 1'b1;
        ce                 = 1'b1;
        scr_bypass         = 1'b0;
        strap_address_pins = 5'h00;
        rx_cg              = '0;
        t_seed();
        t_rate();
        t_hold();
        t_decode();
        t_scramble();
        t_frame();
        t_underrun();
        end_sim();
    end
endmodule // fetx_tx_pcs_bench
`default_nettype wire
